/* i2c_host_read_ack_port_tb.sv */
// Bench joining both ends of the link over one interface.
// Drives the host command port and the device stream and event inputs.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_read_ack_port_tb;
  import i2crp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rx_valid = 1'b0, cmd_valid = 1'b0;
  logic cmd_read = 1'b0, rd_ready = 1'b0, poll_mode = 1'b0;
  i2crp_byte_t rx_data = 8'h00, cmd_reg = 8'h00, cmd_len = 8'h01;
  i2crp_byte_t cmd_wdata = 8'h00, evt = 8'h00;
  logic rx_ready, tx_valid, ready, cmd_ready, rd_valid, done, nack;
  logic dev_ready, irq_pending;
  i2crp_byte_t tx_data, rd_data, status, tx_last;
  i2crp_byte_t got[$];
  int err_total = 0, checks_done = 0, wt = 0;
  always #5 clk = ~clk;
  i2crp_if bus ();
  i2crp_dev #(.READY_CNT(50)) u_i2crp_dev (.CLK(clk), .RST_N(rst_n),
    .BUS(bus), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .EVT(evt), .READY(ready));
  i2crp_host #(.POLL(200)) u_i2crp_host (.CLK(clk), .RST_N(rst_n),
    .BUS(bus), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_READ(cmd_read), .CMD_REG(cmd_reg), .CMD_LEN(cmd_len),
    .CMD_WDATA(cmd_wdata), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .RD_READY(rd_ready), .DONE(done), .NACK(nack),
    .DEV_READY(dev_ready), .POLL_MODE(poll_mode),
    .IRQ_PENDING(irq_pending), .STATUS(status));
  i2crp_assertions u_chk (.CLK(clk), .RST_N(rst_n), .scl(bus.scl),
    .sda(bus.sda), .sda_d_oe_n(bus.sda_d_oe_n),
    .irq_oe_n(bus.irq_oe_n), .irq_n(bus.irq_n));
  always @(posedge clk)
    if (tx_valid === 1'b1)
      tx_last <= tx_data;
  task automatic chk(input i2crp_byte_t seen, input i2crp_byte_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 20000)
    begin
      err_total++;
      complete_run();
    end
  endtask
  // Read bytes are popped only after stall cycles, so the host buffer fills
  task automatic xfer(input logic rd, input i2crp_byte_t rg,
    input i2crp_byte_t ln, input i2crp_byte_t wd, input int stall);
    int n;
    got.delete();
    {cmd_valid, cmd_read, cmd_reg, cmd_len, cmd_wdata} <= {1'b1, rd, rg, ln, wd};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 20000);
    tmo(n);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      n++;
      if (rd_valid === 1'b1 && rd_ready === 1'b1)
        got.push_back(rd_data);
      rd_ready <= (n > stall);
    end
    // Let an edge pass first: the loop may have set rd_ready in this step
    @(posedge clk);
    rd_ready <= 1'b0;
    tmo(n);
  endtask
  task automatic push(input i2crp_byte_t d);
    {rx_valid, rx_data} <= {1'b1, d};
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic until_irq(input logic v);
    int n;
    n = 0;
    while (irq_pending !== v && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    while (dev_ready !== 1'b1 && wt < 20000)
    begin
      @(posedge clk);
      wt++;
    end
    tmo(wt);
    chk(8'(ready), 8'h01);
    chk(8'(wt > 50), 8'h01);
    xfer(1'b0, REG_MASK, 8'h01, 8'h04, 0);
    chk(8'(nack), 8'h00);
    xfer(1'b0, 8'h05, 8'h01, 8'h00, 0);
    chk(8'(nack), 8'h01);
    xfer(1'b1, REG_MASK, 8'h03, 8'h00, 800);
    chk(8'(got.size()), 8'h03);
    chk(got[0], 8'h04);
    chk(got[1], 8'h00);
    chk(got[2], ID_VALUE);
    push(8'h11);
    push(8'h22);
    chk(8'(rx_ready), 8'h00);
    xfer(1'b1, REG_HOLD, 8'h03, 8'h00, 0);
    chk(got[0], 8'h11);
    chk(got[1], 8'h22);
    chk(got[2], EMPTY_READ);
    xfer(1'b0, REG_HOLD, 8'h01, 8'h5A, 0);
    chk(tx_last, 8'h5A);
    // A masked event alone must leave the request line released
    evt <= 8'h02;
    @(posedge clk);
    evt <= 8'h00;
    repeat (20) @(posedge clk);
    chk(8'(irq_pending), 8'h00);
    evt <= 8'h04;
    @(posedge clk);
    evt <= 8'h00;
    until_irq(1'b1);
    chk(8'(bus.irq_n), 8'h00);
    xfer(1'b1, REG_STATUS, 8'h01, 8'h00, 0);
    chk(got[0], 8'h06);
    until_irq(1'b0);
    chk(8'(bus.irq_n), 8'h01);
    poll_mode <= 1'b1;
    evt <= 8'h04;
    @(posedge clk);
    evt <= 8'h00;
    // Line pulled, first poll still far off: the host must not flag it
    repeat (20) @(posedge clk);
    chk(8'(bus.irq_n), 8'h00);
    chk(8'(irq_pending), 8'h00);
    wt = 0;
    while (status !== 8'h04 && wt < 20000)
    begin
      @(posedge clk);
      wt++;
    end
    tmo(wt);
    chk(8'(irq_pending), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire

/* i2crp_assertions.sv */
// Checker for the link wires joining the host end and the device end.
// Assumes resolved SCL and SDA plus the device enables, on one clock.
`timescale 1ns/1ns
`default_nettype none
module i2crp_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe_n,
  input wire logic irq_oe_n,
  input wire logic irq_n
);
  import i2crp_pkg::*;
  logic scl_q, sda_q, rd_q, ack0_q, rdy_q;
  logic [3:0] bit_q;
  logic [7:0] byte_q, sh_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;
  wire ninth = scl & ~scl_q & (bit_q == 4'h8);
  wire rd_data = rd_q & (byte_q != 8'h00);
  wire dat9 = ninth & rd_data;
  wire reg_bit = ninth & (byte_q == 8'h01) & ~rd_q;
  wire bad_reg = reg_bit & (sh_q >= REG_COUNT);
  wire good_reg = reg_bit & ack0_q & (sh_q < REG_COUNT);
  wire rd_addr = ninth & (byte_q == 8'h00) & rdy_q & (sh_q == {DEV_ADDR, 1'b1});
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      {scl_q, sda_q, rd_q, ack0_q, rdy_q} <= 5'h18;
      bit_q <= 4'h0;
      byte_q <= 8'h00;
      sh_q <= 8'h00;
    end
    else
    begin
      {scl_q, sda_q} <= {scl, sda};
      if (start)
        {bit_q, byte_q} <= 12'h000;
      else if (ninth)
        {bit_q, byte_q} <= {4'h0, byte_q + 8'h01};
      else if (scl && !scl_q)
        {bit_q, sh_q} <= {bit_q + 4'h1, sh_q[6:0], sda};
      if (ninth && byte_q == 8'h00)
        {rd_q, ack0_q, rdy_q} <= {sh_q[0], ~sda, rdy_q | ~sda};
    end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  chk_irq_open_drain: assert property (
    !irq_oe_n |-> !irq_n)
    else $error("request line high while pulled");
  chk_read_bit_steady: assert property (
    scl && scl_q && rd_data |-> $stable(sda_d_oe_n))
    else $error("device data moved while clock high");
  chk_bad_reg_nack: assert property (
    bad_reg |-> sda_d_oe_n [*6])
    else $error("invalid register address acknowledged");
  chk_good_reg_ack: assert property (
    good_reg |-> !sda_d_oe_n)
    else $error("valid register address not acknowledged");
  chk_read_addr_ack: assert property (
    rd_addr |-> !sda_d_oe_n)
    else $error("read address not acknowledged");
  chk_ack_held_high: assert property (
    ninth && !sda_d_oe_n |-> !sda_d_oe_n [*6])
    else $error("acknowledge dropped in ninth pulse");
  chk_receiver_acks: assert property (
    dat9 |-> sda_d_oe_n)
    else $error("device drove the host acknowledge slot");
  chk_nack_then_stop: assert property (
    dat9 && sda |-> ##[1:40] stop)
    else $error("no stop after final read byte");
  cover property (dat9 && byte_q == 8'h03);
  cover property (bad_reg);
  cover property (!irq_oe_n);
endmodule
`default_nettype wire

/* i2crp_dev.sv */
// i2crp_dev: target end of the link with a small register file, a
// receive-holding stream buffer and an open-drain interrupt request.
// Assumes SCL and SDA come from another domain; both are resynchronised.
`timescale 1ns/1ns
`default_nettype none
module i2crp_dev #(
  parameter int READY_CNT = i2crp_pkg::READY_CYCLES,
  parameter logic [6:0] ADDR = i2crp_pkg::DEV_ADDR
) (
  input wire logic CLK,
  input wire logic RST_N,
  i2crp_if.dev BUS,
  input wire logic RX_VALID,
  input wire i2crp_pkg::i2crp_byte_t RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output i2crp_pkg::i2crp_byte_t TX_DATA,
  input wire i2crp_pkg::i2crp_byte_t EVT,
  output logic READY
);
  import i2crp_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} i2crp_dst_t;
  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} i2crp_kind_t;

  localparam int RW = $clog2(READY_CNT + 1);

  function automatic i2crp_byte_t adv(input i2crp_byte_t p);
    adv = (p == REG_HOLD) ? p : p + 8'h01;
  endfunction

  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic [RW-1:0] rdy_cnt_reg;
  logic ready_reg;
  i2crp_dst_t st_reg;
  i2crp_kind_t kind_reg;
  logic [3:0] cnt_reg;
  i2crp_byte_t sh_reg;
  i2crp_byte_t ptr_reg;
  logic ack_reg;
  logic rnw_reg;
  logic hack_reg;
  logic sda_low_reg;
  logic irq_low_reg;
  i2crp_byte_t mask_reg;
  i2crp_byte_t status_reg;
  logic tx_valid_reg;
  i2crp_byte_t tx_data_reg;
  i2crp_byte_t fifo_mem [2];
  logic fifo_wp_reg;
  logic fifo_rp_reg;
  logic [1:0] fifo_cnt_reg;

  // Pins from the far side: two flops, then a third for edge finding
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= BUS.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= BUS.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  wire scl_rise = scl_s2_reg & ~scl_s3_reg;
  wire scl_fall = ~scl_s2_reg & scl_s3_reg;
  wire scl_high = scl_s2_reg & scl_s3_reg;
  wire bus_start = scl_high & sda_s3_reg & ~sda_s2_reg;
  wire bus_stop = scl_high & ~sda_s3_reg & sda_s2_reg;

  // The target stays deaf to its address until the settle time is over
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rdy_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end
    else if (!ready_reg)
    begin
      rdy_cnt_reg <= rdy_cnt_reg + 1'b1;
      ready_reg <= (rdy_cnt_reg == RW'(READY_CNT - 1));
    end
  end

  wire in_rx = (st_reg == D_RX);
  wire in_tx = (st_reg == D_TX);
  wire rx_end = in_rx & scl_fall & (cnt_reg == BIT_ACK);
  wire rx_slot_end = in_rx & scl_fall & (cnt_reg == BIT_ACK_DONE);
  wire tx_slot_end = in_tx & scl_fall & (cnt_reg == BIT_ACK_DONE);
  wire addr_hit = (sh_reg[7:1] == ADDR) & ready_reg;
  wire reg_ok = (sh_reg < REG_COUNT);
  wire rx_ack = (kind_reg == K_ADDR) ? addr_hit :
                (kind_reg == K_REG) ? reg_ok : 1'b1;
  wire ld_first = rx_slot_end & ack_reg & (kind_reg == K_ADDR) & rnw_reg;
  wire ld_next = tx_slot_end & hack_reg;
  wire ld_byte = ld_first | ld_next;
  wire wr_byte = rx_end & (kind_reg == K_DATA);
  wire fifo_has = (fifo_cnt_reg != 2'h0);
  wire i2crp_byte_t hold_val = fifo_has ? fifo_mem[fifo_rp_reg] : EMPTY_READ;
  wire i2crp_byte_t rd_val = (ptr_reg == REG_HOLD) ? hold_val :
                             (ptr_reg == REG_MASK) ? mask_reg :
                             (ptr_reg == REG_STATUS) ? status_reg :
                             (ptr_reg == REG_ID) ? ID_VALUE : EMPTY_READ;
  wire fifo_pop = ld_byte & (ptr_reg == REG_HOLD) & fifo_has;
  wire fifo_push = RX_VALID & RX_READY;
  wire i2crp_byte_t stat_clr = (ld_byte & (ptr_reg == REG_STATUS)) ?
                               status_reg : 8'h00;

  assign RX_READY = (fifo_cnt_reg != 2'h2);

  // Two-entry buffer: the stream stalls rather than drops when full
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end
    else
    begin
      fifo_wp_reg <= fifo_wp_reg ^ fifo_push;
      fifo_rp_reg <= fifo_rp_reg ^ fifo_pop;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (fifo_push)
      fifo_mem[fifo_wp_reg] <= RX_DATA;
  end

  // A new event beats a clear-on-read in the same cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      status_reg <= 8'h00;
      mask_reg <= MASK_RESET;
      irq_low_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end
    else
    begin
      status_reg <= (status_reg & ~stat_clr) | EVT;
      if (wr_byte && ptr_reg == REG_MASK)
        mask_reg <= sh_reg;
      irq_low_reg <= |(status_reg & mask_reg); // RULE_14
      tx_valid_reg <= wr_byte & (ptr_reg == REG_HOLD);
      if (wr_byte)
        tx_data_reg <= sh_reg;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_reg <= D_IDLE;
      kind_reg <= K_ADDR;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ack_reg <= 1'b0;
      rnw_reg <= 1'b0;
      hack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      st_reg <= D_RX;
      kind_reg <= K_ADDR;
      cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end
    else if (bus_stop)
    begin
      st_reg <= D_IDLE;
      sda_low_reg <= 1'b0;
    end
    else
    begin
      case (st_reg)
        D_RX:
        begin
          if (scl_rise && cnt_reg < BIT_ACK)
          begin
            sh_reg <= {sh_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (rx_end)
          begin
            ack_reg <= rx_ack;
            sda_low_reg <= rx_ack; // RULE_02 RULE_03 RULE_07 RULE_08 RULE_09
            cnt_reg <= BIT_ACK_DONE;
            if (kind_reg == K_ADDR)
              rnw_reg <= sh_reg[0];
            if (kind_reg == K_REG && rx_ack)
              ptr_reg <= sh_reg;
            if (kind_reg == K_DATA)
              ptr_reg <= adv(ptr_reg);
          end
          else if (rx_slot_end)
          begin
            cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            if (!ack_reg)
              st_reg <= D_IDLE;
            else if (ld_first)
            begin
              st_reg <= D_TX;
              sh_reg <= rd_val;
              sda_low_reg <= ~rd_val[7];
              ptr_reg <= adv(ptr_reg); // RULE_13
            end
            else
              kind_reg <= (kind_reg == K_ADDR) ? K_REG : K_DATA;
          end
        end
        D_TX:
        begin
          if (scl_fall && cnt_reg < BIT_DATA_END)
          begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            sda_low_reg <= ~sh_reg[6]; // RULE_04
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == BIT_DATA_END)
          begin
            sda_low_reg <= 1'b0;
            cnt_reg <= BIT_ACK;
          end
          else if (scl_rise && cnt_reg == BIT_ACK)
          begin
            hack_reg <= ~sda_s2_reg;
            cnt_reg <= BIT_ACK_DONE;
          end
          else if (tx_slot_end)
          begin
            cnt_reg <= 4'h0;
            if (ld_next)
            begin
              sh_reg <= rd_val;
              sda_low_reg <= ~rd_val[7];
              ptr_reg <= adv(ptr_reg); // RULE_13
            end
            else
              st_reg <= D_IDLE;
          end
        end
        default:
          sda_low_reg <= 1'b0;
      endcase
    end
  end

  assign BUS.sda_d_o = 1'b0;
  assign BUS.sda_d_oe_n = ~sda_low_reg;
  // Pulls low only; the release level comes from the pull-up
  assign BUS.irq_o = 1'b0;
  assign BUS.irq_oe_n = ~irq_low_reg; // RULE_11
  assign TX_VALID = tx_valid_reg;
  assign TX_DATA = tx_data_reg;
  assign READY = ready_reg;
endmodule
`default_nettype wire

/* i2crp_host.sv */
// i2crp_host: bus controller end; makes SCL by dividing its own clock,
// runs register reads and writes, waits for the target after reset and
// can poll the status register instead of watching the request line.
// Assumes SDA and the request line come from another domain.
`timescale 1ns/1ns
`default_nettype none
module i2crp_host #(
  parameter int QUARTER = i2crp_pkg::SCL_QUARTER,
  parameter int POLL = i2crp_pkg::POLL_CYCLES,
  parameter logic [6:0] ADDR = i2crp_pkg::DEV_ADDR
) (
  input wire logic CLK,
  input wire logic RST_N,
  i2crp_if.host BUS,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_READ,
  input wire i2crp_pkg::i2crp_byte_t CMD_REG,
  input wire i2crp_pkg::i2crp_byte_t CMD_LEN,
  input wire i2crp_pkg::i2crp_byte_t CMD_WDATA,
  output logic RD_VALID,
  output i2crp_pkg::i2crp_byte_t RD_DATA,
  input wire logic RD_READY,
  output logic DONE,
  output logic NACK,
  output logic DEV_READY,
  input wire logic POLL_MODE,
  output logic IRQ_PENDING,
  output i2crp_pkg::i2crp_byte_t STATUS
);
  import i2crp_pkg::*;

  typedef enum logic [3:0] {H_IDLE, H_START, H_ADDRW, H_REG, H_WDATA,
    H_RSTART, H_ADDRR, H_RDATA, H_WAIT, H_STOP} i2crp_hst_t;
  typedef enum logic [1:0] {S_USER, S_BOOT, S_POLL} i2crp_src_t;

  localparam int PW = $clog2(POLL + 1);

  logic sda_s1_reg, sda_s2_reg, irq_s1_reg, irq_s2_reg;
  i2crp_hst_t st_reg;
  i2crp_src_t src_reg;
  logic [7:0] q_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx9_reg, rx9_reg;
  i2crp_byte_t reg_a_reg, len_reg, wdata_reg, cap_reg, status_reg;
  logic rd_reg, nack_reg, done_reg, ready_reg, pend_reg;
  logic scl_low_reg, sda_low_reg;
  logic [PW-1:0] poll_cnt_reg;
  logic poll_due_reg;
  i2crp_byte_t fifo_mem [2];
  logic fifo_wp_reg, fifo_rp_reg;
  logic [1:0] fifo_cnt_reg;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      irq_s1_reg <= 1'b1;
      irq_s2_reg <= 1'b1;
    end
    else
    begin
      sda_s1_reg <= BUS.sda;
      sda_s2_reg <= sda_s1_reg;
      irq_s1_reg <= BUS.irq_n;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  wire tick = (q_reg == 8'(QUARTER - 1));
  wire is_cond = (st_reg == H_START) | (st_reg == H_RSTART) |
                 (st_reg == H_STOP);
  wire is_byte = (st_reg == H_ADDRW) | (st_reg == H_REG) |
                 (st_reg == H_WDATA) | (st_reg == H_ADDRR) |
                 (st_reg == H_RDATA);
  wire [3:0] bidx = 4'h8 - bit_reg;
  wire scl_low_c = is_cond ? (ph_reg == 2'h0 ||
                   (ph_reg == 2'h3 && st_reg != H_STOP)) :
                   is_byte ? (ph_reg < 2'h2) : (st_reg == H_WAIT);
  wire sda_low_c = is_cond ? ((st_reg == H_STOP) ? (ph_reg < 2'h2) :
                   (ph_reg > 2'h1)) : is_byte & ~tx9_reg[bidx];
  wire byte_end = is_byte & tick & (ph_reg == 2'h3) & (bit_reg == BIT_ACK);
  wire cond_end = is_cond & tick & (ph_reg == 2'h3);
  wire got_ack = ~rx9_reg[0];
  wire last_rd = (len_reg == 8'h01);
  wire fifo_push = byte_end & (st_reg == H_RDATA) & (src_reg == S_USER);
  wire fifo_pop = RD_VALID & RD_READY;
  wire room = (src_reg != S_USER) | (fifo_cnt_reg != 2'h2);
  wire idle = (st_reg == H_IDLE);
  wire go_boot = idle & ~ready_reg;
  wire go_poll = idle & ready_reg & poll_due_reg;
  wire go_user = CMD_VALID & CMD_READY;

  assign CMD_READY = idle & ready_reg & ~poll_due_reg;
  assign RD_VALID = (fifo_cnt_reg != 2'h0);
  assign RD_DATA = fifo_mem[fifo_rp_reg];

  // Two-entry read buffer; a full buffer holds SCL low between bytes
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end
    else
    begin
      fifo_wp_reg <= fifo_wp_reg ^ fifo_push;
      fifo_rp_reg <= fifo_rp_reg ^ fifo_pop;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (fifo_push)
      fifo_mem[fifo_wp_reg] <= rx9_reg[8:1];
  end

  // Polled mode reads status on a fixed interval and ignores the line
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      poll_cnt_reg <= '0;
      poll_due_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      pend_reg <= ~POLL_MODE & ~irq_s2_reg; // RULE_12
      if (go_poll)
        poll_due_reg <= 1'b0;
      else if (ready_reg && POLL_MODE && !poll_due_reg)
      begin
        poll_cnt_reg <= poll_cnt_reg + 1'b1;
        if (poll_cnt_reg == PW'(POLL - 1))
        begin
          poll_cnt_reg <= '0;
          poll_due_reg <= 1'b1; // RULE_12
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_reg <= H_IDLE;
      src_reg <= S_USER;
      q_reg <= 8'h00;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx9_reg <= 9'h1FF;
      rx9_reg <= 9'h000;
      reg_a_reg <= 8'h00;
      len_reg <= 8'h01;
      wdata_reg <= 8'h00;
      cap_reg <= 8'h00;
      status_reg <= 8'h00;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end
    else
    begin
      scl_low_reg <= scl_low_c;
      sda_low_reg <= sda_low_c; // RULE_07 RULE_08 RULE_09
      done_reg <= 1'b0;
      q_reg <= (idle || st_reg == H_WAIT || tick) ? 8'h00 : q_reg + 8'h01;
      if (tick)
        ph_reg <= ph_reg + 2'h1;
      if (tick && ph_reg == 2'h3 && is_byte)
        bit_reg <= bit_reg + 4'h1;
      if (is_byte && tick && ph_reg == 2'h2)
        rx9_reg <= {rx9_reg[7:0], sda_s2_reg};
      case (st_reg)
        H_IDLE:
        begin
          ph_reg <= 2'h0;
          if (go_boot || go_poll || go_user)
          begin
            st_reg <= H_START;
            src_reg <= go_boot ? S_BOOT : go_poll ? S_POLL : S_USER;
            rd_reg <= go_user ? CMD_READ : 1'b1;
            reg_a_reg <= go_boot ? REG_ID : go_poll ? REG_STATUS : CMD_REG;
            len_reg <= (go_user && CMD_LEN != 8'h00) ? CMD_LEN : 8'h01;
            wdata_reg <= CMD_WDATA;
          end
        end
        H_START:
          if (cond_end)
          begin
            st_reg <= H_ADDRW;
            bit_reg <= 4'h0;
            tx9_reg <= {ADDR, 1'b0, 1'b1};
          end
        H_ADDRW, H_REG, H_WDATA, H_ADDRR, H_RDATA:
          if (byte_end)
          begin
            bit_reg <= 4'h0;
            st_reg <= H_STOP;
            nack_reg <= ~got_ack;
            if (st_reg == H_ADDRW && got_ack)
            begin
              st_reg <= H_REG;
              tx9_reg <= {reg_a_reg, 1'b1};
            end
            if (st_reg == H_REG && got_ack)
            begin
              st_reg <= rd_reg ? H_RSTART : H_WDATA; // RULE_01
              tx9_reg <= {wdata_reg, 1'b1};
            end
            if (st_reg == H_ADDRR && got_ack)
              st_reg <= H_WAIT;
            if (st_reg == H_RDATA)
            begin
              nack_reg <= 1'b0;
              cap_reg <= rx9_reg[8:1];
              len_reg <= len_reg - 8'h01;
              st_reg <= last_rd ? H_STOP : H_WAIT; // RULE_06
            end
          end
        H_RSTART:
          if (cond_end)
          begin
            st_reg <= H_ADDRR;
            bit_reg <= 4'h0;
            tx9_reg <= {ADDR, 1'b1, 1'b1}; // RULE_01
          end
        H_WAIT:
        begin
          ph_reg <= 2'h0;
          if (room)
          begin
            st_reg <= H_RDATA;
            tx9_reg <= {8'hFF, last_rd}; // RULE_05 RULE_06
          end
        end
        H_STOP:
          if (cond_end)
          begin
            st_reg <= H_IDLE;
            done_reg <= (src_reg == S_USER);
            if (src_reg == S_BOOT && !nack_reg && cap_reg == ID_VALUE)
              ready_reg <= 1'b1; // RULE_10
            if (src_reg == S_POLL && !nack_reg)
              status_reg <= cap_reg;
          end
        default:
          st_reg <= H_IDLE;
      endcase
    end
  end

  assign BUS.scl_o = 1'b0;
  assign BUS.scl_oe_n = ~scl_low_reg;
  assign BUS.sda_h_o = 1'b0;
  assign BUS.sda_h_oe_n = ~sda_low_reg;
  assign DONE = done_reg;
  assign NACK = nack_reg;
  assign DEV_READY = ready_reg;
  assign IRQ_PENDING = pend_reg;
  assign STATUS = status_reg;
endmodule
`default_nettype wire

/* i2crp_if.sv */
// i2crp_if: the two-wire link plus interrupt request between both ends.
// Open-drain wires with pull-ups: a pin reads low when any enable is low.
`timescale 1ns/1ns
`default_nettype none
interface i2crp_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic irq_o;
  logic irq_oe_n;
  logic scl;
  logic sda;
  logic irq_n;
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  assign irq_n = irq_oe_n | irq_o;
  modport dev (
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe_n,
    output irq_o,
    output irq_oe_n
  );
  modport host (
    output scl_o,
    output scl_oe_n,
    output sda_h_o,
    output sda_h_oe_n,
    input scl,
    input sda,
    input irq_n
  );
endinterface
`default_nettype wire

/* i2crp_pkg.sv */
// i2crp_pkg: constants shared by the device end and the host end of the
// I2C read/acknowledge port. Assumes both ends run on a 100 MHz core clock.
// What this block does
// RULE_01: Read: register write, repeated START, address+read.
// RULE_02: Device acknowledges only valid register addresses.
// RULE_03: Device acknowledges own read address before data.
// RULE_04: Device sends eight bits per byte, one per clock.
// RULE_05: Host acknowledges every burst byte except last.
// RULE_06: Host ends read with NACK then STOP.
// RULE_07: Whoever receives a byte produces its acknowledge.
// RULE_08: ACK: SDA low across ninth clock high phase.
// RULE_09: NACK: SDA released across whole ninth clock.
// RULE_10: Host polls known register until device ready.
// RULE_11: Interrupt request is open-drain, pulls low only.
// RULE_12: Polled host ignores request, reads status periodically.
// RULE_13: Burst read advances address, except holding register.
// RULE_14: Request held low while enabled event pending.
package i2crp_pkg;
  typedef logic [7:0] i2crp_byte_t;
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int T_READY_US = 200;
  localparam int READY_CYCLES = T_READY_US * CLK_MHZ;
  localparam int T_SCL_NS = 160;
  localparam int SCL_QUARTER = T_SCL_NS / (4 * CLK_NS);
  localparam int POLL_CYCLES = 20000;
  // Arbitrary target address and identity value
  localparam logic [6:0] DEV_ADDR = 7'h2C;
  localparam i2crp_byte_t ID_VALUE = 8'hA5;
  localparam i2crp_byte_t REG_HOLD = 8'h00;
  localparam i2crp_byte_t REG_MASK = 8'h01;
  localparam i2crp_byte_t REG_STATUS = 8'h02;
  localparam i2crp_byte_t REG_ID = 8'h03;
  localparam i2crp_byte_t REG_COUNT = 8'h04;
  localparam i2crp_byte_t MASK_RESET = 8'h00;
  localparam i2crp_byte_t EMPTY_READ = 8'h00;
  localparam logic [3:0] BIT_DATA_END = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
endpackage
